// *** dsrb_pkg.sv ***
package dsrb_pkg;
  // Register addresses on the control interface
  localparam logic [7:0] DSRB_ADDR_CHIP_STATUS = 8'h40;
  localparam logic [7:0] DSRB_ADDR_PIN_LEVEL = 8'h41;
  localparam logic [7:0] DSRB_ADDR_RATIO_LSB = 8'h42;
  localparam logic [7:0] DSRB_ADDR_RATIO_MSB = 8'h45;
  localparam logic [7:0] DSRB_ADDR_CSTAT_LSB = 8'h46;
  localparam logic [7:0] DSRB_ADDR_CSTAT_MSB = 8'h5d;
  // Chip status field positions
  localparam int DSRB_POS_REVISION = 5;
  localparam int DSRB_POS_ID_LO = 2;
  localparam int DSRB_POS_AUTOMUTE = 1;
  localparam int DSRB_POS_LOCK = 0;
  // Pin status field position
  localparam int DSRB_POS_PIN_ONE = 0;
  // Consumer channel status fields, byte 0
  localparam int DSRB_POS_CS_PRO = 0;
  localparam int DSRB_POS_CS_DATA = 1;
  localparam int DSRB_POS_CS_NOCOPY = 2;
  localparam int DSRB_POS_CS_PREEMPH = 3;
  localparam int DSRB_POS_CS_FOURCH = 5;
  // Consumer channel status byte indexes
  localparam int DSRB_CS_BYTE_CATEGORY = 1;
  localparam int DSRB_CS_BYTE_NUMBERS = 2;
  localparam int DSRB_CS_BYTE_FREQ = 3;
  localparam int DSRB_CS_BYTE_WLEN = 4;
  // Values after reset
  localparam logic [31:0] DSRB_RATIO_RESET = 32'h0000_0000;
  localparam logic [7:0] DSRB_DATA_RESET = 8'h00;
  localparam logic [1:0] DSRB_SYNC_RESET = 2'h0;
  // Widths
  localparam int DSRB_CS_BYTES = 24;
endpackage

// *** dsrb_cs_fields.sv ***
`timescale 1ns/1ps
// Splits the consumer fields out of the received channel status block
module dsrb_cs_fields
  import dsrb_pkg::*;
(
  // Channel status block
  input wire logic [191:0] i_cstat,
  // Format and byte 0 flags
  output logic o_professional,
  output logic o_is_data,
  output logic o_no_copyright,
  output logic o_preemphasis,
  output logic o_four_channel,
  // Consumer bytes 1 to 4
  output logic [7:0] o_category,
  output logic [3:0] o_source_num,
  output logic [3:0] o_channel_num,
  output logic [3:0] o_freq_code,
  output logic [1:0] o_clock_accuracy,
  output logic o_wlen_max24,
  output logic [2:0] o_wlen_code
);
  // Consumer meanings hold only when the format bit is clear
  logic cons;
  assign o_professional = i_cstat[DSRB_POS_CS_PRO];
  assign cons = ~o_professional;
  // Byte 0 flags
  assign o_is_data = cons & i_cstat[DSRB_POS_CS_DATA];
  assign o_no_copyright = cons & i_cstat[DSRB_POS_CS_NOCOPY];
  assign o_preemphasis = cons & i_cstat[DSRB_POS_CS_PREEMPH];
  assign o_four_channel = cons & i_cstat[DSRB_POS_CS_FOURCH];
  // Category code
  assign o_category = cons ? i_cstat[DSRB_CS_BYTE_CATEGORY*8 +: 8] : 8'h00;
  // Source number low nibble, channel number high nibble
  assign o_source_num = cons ? i_cstat[DSRB_CS_BYTE_NUMBERS*8 +: 4] : 4'h0;
  assign o_channel_num = cons ? i_cstat[DSRB_CS_BYTE_NUMBERS*8+4 +: 4] : 4'h0;
  // Sample frequency and clock accuracy
  assign o_freq_code = cons ? i_cstat[DSRB_CS_BYTE_FREQ*8 +: 4] : 4'h0;
  assign o_clock_accuracy = cons ? i_cstat[DSRB_CS_BYTE_FREQ*8+4 +: 2] : 2'h0;
  // Word length: max flag at bit 0, code above
  assign o_wlen_max24 = cons & i_cstat[DSRB_CS_BYTE_WLEN*8];
  assign o_wlen_code = cons ? i_cstat[DSRB_CS_BYTE_WLEN*8+1 +: 3] : 3'h0;
endmodule

// *** dsrb_status_bank.sv ***
`timescale 1ns/1ps
module dsrb_status_bank
  import dsrb_pkg::*;
#(
  // Arbitrary neutral identity values
  parameter logic [2:0] DEVICE_IDENTIFIER = 3'h1,
  parameter logic REVISION = 1'b0
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register read port from the control interface
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Live status from the audio path
  input wire logic i_automute_active,
  input wire logic i_lock,
  input wire logic [31:0] i_rate_ratio,
  input wire logic [191:0] i_cstat,
  // Pin from outside
  input wire logic i_general_pin_one,
  // Decoded consumer fields
  output logic o_professional,
  output logic o_is_data,
  output logic o_no_copyright,
  output logic o_preemphasis,
  output logic o_four_channel,
  output logic [7:0] o_category,
  output logic [3:0] o_source_num,
  output logic [3:0] o_channel_num,
  output logic [3:0] o_freq_code,
  output logic [1:0] o_clock_accuracy,
  output logic o_wlen_max24,
  output logic [2:0] o_wlen_code
);
  // All state of the bank
  typedef struct packed {
    logic [1:0] pin_sync; // Pin synchroniser, bit 0 first stage
    logic [31:0] ratio_hold; // Latched rate ratio
    logic [7:0] rdata; // Read data
    logic rvalid; // Read answer strobe
  } dsrb_state_t;

  dsrb_state_t state_reg; // Registered state
  dsrb_state_t state_next; // Next value of the state

  // Byte registers that make up the rate ratio
  localparam int RATIO_BYTES = 4;

  // Byte lanes of the live channel status block
  logic [7:0] cstat_byte [DSRB_CS_BYTES];
  // Byte lanes of the held rate ratio copy
  logic [7:0] hold_byte [RATIO_BYTES];

  // Address classes of the present address
  logic hit_chip; // Chip status register
  logic hit_pin; // Pin status register
  logic hit_ratio_lsb; // Capturing ratio byte
  logic hit_ratio_hi; // Upper ratio bytes
  logic hit_cstat; // Channel status bytes
  // Read of the capturing byte
  logic capture;

  // Chip status byte assembly
  function automatic logic [7:0] dsrb_chip_byte(input logic mute, input logic lock);
    logic [7:0] b;
    b = 8'h00;
    b[DSRB_POS_REVISION] = REVISION;
    b[DSRB_POS_ID_LO +: 3] = DEVICE_IDENTIFIER;
    b[DSRB_POS_AUTOMUTE] = mute;
    b[DSRB_POS_LOCK] = lock;
    return b;
  endfunction

  // Inclusive address range test, shared by two decodes
  function automatic logic dsrb_in_range(input logic [7:0] addr, input logic [7:0] lo,
    input logic [7:0] hi);
    return (addr >= lo) && (addr <= hi);
  endfunction

  // One lane per channel status register
  genvar g;
  generate
    for (g = 0; g < DSRB_CS_BYTES; g = g + 1)
    begin : g_cstat
      // Lowest register carries the lowest bits
      assign cstat_byte[g] = i_cstat[g*8 +: 8];
    end
  endgenerate

  // One lane per ratio register, lowest byte first
  generate
    for (g = 0; g < RATIO_BYTES; g = g + 1)
    begin : g_ratio
      // Upper registers show the held copy; the low byte register reads the live ratio
      assign hold_byte[g] = state_reg.ratio_hold[g*8 +: 8];
    end
  endgenerate

  // Address decode; the classes never overlap
  assign hit_chip = (i_addr == DSRB_ADDR_CHIP_STATUS);
  assign hit_pin = (i_addr == DSRB_ADDR_PIN_LEVEL);
  assign hit_ratio_lsb = (i_addr == DSRB_ADDR_RATIO_LSB);
  // Upper ratio bytes start one above the capturing byte
  assign hit_ratio_hi = dsrb_in_range(i_addr, DSRB_ADDR_RATIO_LSB + 8'h01,
    DSRB_ADDR_RATIO_MSB);
  // Twenty-four channel status registers
  assign hit_cstat = dsrb_in_range(i_addr, DSRB_ADDR_CSTAT_LSB, DSRB_ADDR_CSTAT_MSB);
  // Only this read or a reset may change the held copy
  assign capture = i_rd & hit_ratio_lsb;

  // Next state and read mux
  always_comb
  begin
    logic [7:0] ofs;
    ofs = 8'h00;
    state_next = state_reg;
    // Second stage reads only the first
    state_next.pin_sync = {state_reg.pin_sync[0], i_general_pin_one};
    // Answer strobe follows the request by one cycle
    state_next.rvalid = i_rd;
    // Whole ratio taken at once so the four bytes belong together
    if (capture)
    begin
      state_next.ratio_hold = i_rate_ratio;
    end
    // Read mux, one register per request
    if (i_rd)
    begin
      if (hit_chip)
      begin
        // Live flags, nothing cleared
        state_next.rdata = dsrb_chip_byte(i_automute_active, i_lock);
      end
      else if (hit_pin)
      begin
        // Reserved bits zero
        state_next.rdata = 8'h00;
        state_next.rdata[DSRB_POS_PIN_ONE] = state_reg.pin_sync[1];
      end
      else if (hit_ratio_lsb)
      begin
        // Low byte answered live, same value as captured
        state_next.rdata = i_rate_ratio[7:0];
      end
      else if (hit_ratio_hi)
      begin
        // Upper bytes from the held copy, which stays untouched
        ofs = i_addr - DSRB_ADDR_RATIO_LSB;
        state_next.rdata = hold_byte[ofs[1:0]];
      end
      else if (hit_cstat)
      begin
        // Offset from the first channel status register
        ofs = i_addr - DSRB_ADDR_CSTAT_LSB;
        state_next.rdata = cstat_byte[ofs[4:0]];
      end
      else
      begin
        // Unmapped address reads zero
        state_next.rdata = DSRB_DATA_RESET;
      end
    end
    else
    begin
      // No request, read data holds
      state_next.rdata = state_reg.rdata;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // Clear to constants only
      state_reg.pin_sync <= DSRB_SYNC_RESET;
      state_reg.ratio_hold <= DSRB_RATIO_RESET;
      state_reg.rdata <= DSRB_DATA_RESET;
      state_reg.rvalid <= 1'b0;
    end
    else
    begin
      // Whole struct advances together
      state_reg <= state_next;
    end
  end

  // Read answer
  assign o_rdata = state_reg.rdata;
  assign o_rvalid = state_reg.rvalid;

  // Consumer field decoder
  dsrb_cs_fields u_fields (
    .i_cstat(i_cstat),
    .o_professional(o_professional),
    .o_is_data(o_is_data),
    .o_no_copyright(o_no_copyright),
    .o_preemphasis(o_preemphasis),
    .o_four_channel(o_four_channel),
    .o_category(o_category),
    .o_source_num(o_source_num),
    .o_channel_num(o_channel_num),
    .o_freq_code(o_freq_code),
    .o_clock_accuracy(o_clock_accuracy),
    .o_wlen_max24(o_wlen_max24),
    .o_wlen_code(o_wlen_code)
  );
endmodule

// *** dsrb_status_bank_asserts.sv ***
`timescale 1ns/1ps
// Read timing and field mapping seen at the bank ports
module dsrb_status_bank_chk
  import dsrb_pkg::*;
(
  // Clock, reset, read port
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // Live status and decode
  input wire logic i_automute_active,
  input wire logic i_lock,
  input wire logic [31:0] i_rate_ratio,
  input wire logic [191:0] i_cstat,
  input wire logic o_professional,
  input wire logic [3:0] o_freq_code,
  input wire logic o_is_data,
  input wire logic [7:0] o_category
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rvalid; i_rd |=> o_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no answer to read");
  property p_mute; i_rd && i_addr == 8'h40 |=> o_rdata[7:6] == 2'h0 && o_rdata[1] == $past(i_automute_active); endproperty
  a_mute: assert property (p_mute) else $error("mute bit wrong");
  property p_lock; i_rd && i_addr == 8'h40 |=> o_rdata[0] == $past(i_lock); endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_pin; i_rd && i_addr == 8'h41 |=> o_rdata[7:1] == 7'h0; endproperty
  a_pin: assert property (p_pin) else $error("pin spare bits set");
  property p_cs; i_rd && i_addr inside {[8'h46:8'h5d]} |=>
    o_rdata == 8'($past(i_cstat) >> (8 * ($past(i_addr) - 8'h46))); endproperty
  a_cs: assert property (p_cs) else $error("status byte wrong");
  property p_lsb; i_rd && i_addr == 8'h42 |=> o_rdata == $past(i_rate_ratio[7:0]); endproperty
  a_lsb: assert property (p_lsb) else $error("ratio low byte wrong");
  property p_hold; i_rd && i_addr == 8'h42 ##2 i_rd && i_addr == 8'h43 |=>
    o_rdata == $past(i_rate_ratio[15:8], 3); endproperty
  a_hold: assert property (p_hold) else $error("ratio not held");
  property p_pro; o_professional == i_cstat[0]; endproperty
  a_pro: assert property (p_pro) else $error("format bit wrong");
  property p_freq; !i_cstat[0] |-> o_freq_code == i_cstat[27:24]; endproperty
  a_freq: assert property (p_freq) else $error("rate code wrong");
  property p_data; !i_cstat[0] |-> o_is_data == i_cstat[1]; endproperty
  a_data: assert property (p_data) else $error("data flag wrong");
  property p_cat; !i_cstat[0] |-> o_category == i_cstat[15:8]; endproperty
  a_cat: assert property (p_cat) else $error("category wrong");
  property p_pro_cat; i_cstat[0] |-> o_category == 8'h00 && !o_is_data; endproperty
  a_pro_cat: assert property (p_pro_cat) else $error("consumer field in professional");
endmodule
bind dsrb_status_bank dsrb_status_bank_chk u_chk (.i_clk, .i_rst_b, .i_rd, .i_addr, .o_rdata,
  .o_rvalid, .i_automute_active, .i_lock, .i_rate_ratio, .i_cstat, .o_professional,
  .o_freq_code, .o_is_data, .o_category);

// *** dsrb_host.sv ***
`timescale 1ns/1ps
// Host on the read port, one read at a time
module dsrb_host
(
  // Clock and answer
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  // Request
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00
);
  // Request at an edge, answer one cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a; // Released address shows no stale value
    @(posedge i_clk);
    d = {i_rvalid, i_rdata};
  endtask
endmodule

// *** dsrb_status_bank_tb.sv ***
`timescale 1ns/1ps
// Random and corner reads of the status bank
module dsrb_status_bank_tb
  import dsrb_pkg::*;
;
  localparam logic [2:0] ID = 3'h5; // Arbitrary value
  localparam logic REV = 1'b1; // Arbitrary value
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_rd, o_rvalid, o_professional;
  logic i_automute_active, i_lock, i_general_pin_one;
  logic o_is_data, o_no_copyright, o_preemphasis, o_four_channel, o_wlen_max24;
  logic [7:0] i_addr, o_rdata, o_category;
  logic [3:0] o_freq_code, o_source_num, o_channel_num;
  logic [1:0] o_clock_accuracy;
  logic [2:0] o_wlen_code;
  logic [29:0] f;
  logic [31:0] i_rate_ratio, old, got;
  logic [191:0] i_cstat, cs;
  localparam logic [63:0] MCLK_HZ = 64'h5f5e100; // Master clock seen by the host
  logic [8:0] d;
  int fails = 0, comparisons = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  dsrb_status_bank #(.DEVICE_IDENTIFIER(ID), .REVISION(REV)) uut (.i_clk, .i_rst_b, .i_rd,
    .i_addr, .o_rdata, .o_rvalid, .i_automute_active, .i_lock, .i_rate_ratio, .i_cstat,
    .i_general_pin_one, .o_professional, .o_is_data, .o_no_copyright, .o_preemphasis,
    .o_four_channel, .o_category, .o_source_num, .o_channel_num, .o_freq_code,
    .o_clock_accuracy, .o_wlen_max24, .o_wlen_code);
  dsrb_host host (.i_clk, .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_rd(i_rd), .o_addr(i_addr));
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Raw sample rate the host derives from a ratio
  function automatic logic [31:0] raw_sample_rate(input logic [31:0] ratio);
    logic [63:0] p;
    p = {32'h0, ratio} * MCLK_HZ;
    return p[63:32];
  endfunction
  // Consumer fields expected from a block; zero in professional format
  function automatic logic [29:0] consumer_fields(input logic [191:0] c);
    if (c[0])
      return 30'h0;
    return {c[1], c[2], c[3], c[5], c[15:8], c[19:16], c[23:20], c[27:24], c[29:28], c[32],
      c[35:33]};
  endfunction
  // Verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      stop_test;
    end
  end
  // Main sequence
  initial
  begin
    {i_automute_active, i_lock, i_general_pin_one, i_rate_ratio, i_cstat} <= '0;
    void'($urandom(93082));
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    for (int k = 0; k < 10; k++)
    begin
      i_automute_active <= k[1];
      i_lock <= k[0];
      i_general_pin_one <= k[2];
      i_rate_ratio <= $urandom;
      cs = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      cs[0] = k[0];
      if (k == 2)
      begin
        // Corner: experimental category, 192k, 24-bit max with code 100
        cs[15:8] = 8'h40;
        cs[27:24] = 4'he;
        cs[35:32] = 4'h9;
      end
      i_cstat <= cs;
      repeat (3) @(posedge i_clk); // Pin synchroniser settles
      host.rd(DSRB_ADDR_CHIP_STATUS, d);
      chk("chip", d, {1'b1, 2'h0, REV, ID, k[1], k[0]});
      host.rd(DSRB_ADDR_PIN_LEVEL, d);
      chk("pin", d, {1'b1, 7'h0, k[2]});
      old = i_rate_ratio;
      host.rd(DSRB_ADDR_RATIO_LSB, d);
      chk("ratio0", d, {1'b1, old[7:0]});
      got[7:0] = d[7:0];
      i_rate_ratio <= ~old;
      for (int b = 1; b < 4; b++)
      begin
        host.rd(DSRB_ADDR_RATIO_LSB + 8'(b), d);
        chk("ratio", d, {1'b1, old[8*b+:8]});
        got[8*b+:8] = d[7:0];
      end
      chk("rate", raw_sample_rate(got), raw_sample_rate(old));
      host.rd(DSRB_ADDR_RATIO_MSB, d);
      chk("reread", d, {1'b1, old[31:24]});
      for (int n = 0; n < DSRB_CS_BYTES; n++)
      begin
        host.rd(DSRB_ADDR_CSTAT_LSB + 8'(n), d);
        chk("cstat", d, {1'b1, i_cstat[8*n+:8]});
      end
      chk("pro", o_professional, k[0]);
      f = consumer_fields(i_cstat);
      chk("flags", {o_is_data, o_no_copyright, o_preemphasis, o_four_channel}, f[29:26]);
      chk("cat", o_category, f[25:18]);
      chk("numbers", {o_source_num, o_channel_num}, f[17:10]);
      chk("freq", {o_freq_code, o_clock_accuracy}, f[9:4]);
      chk("wlen", {o_wlen_max24, o_wlen_code}, f[3:0]);
      host.rd(8'h00, d);
      chk("unmapped", d, 9'h100);
    end
    // Corner: a reset in mid-run clears the held ratio copy
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    host.rd(DSRB_ADDR_RATIO_LSB + 8'h01, d);
    chk("hold_rst", d, {1'b1, DSRB_RATIO_RESET[15:8]});
    stop_test;
  end
endmodule
